/* File: bpc_checker.sv */
// Port-level assertions for the battery protection controller
`timescale 1ns/10ps
module bpc_checker #(
   parameter N_CELL = 8,
   parameter LOG_AW = 9
) (
   // Clock, reset and watched inputs
   input logic                i_sys_clk,
   input logic                i_arst_n,
   input logic signed [15:0]  i_current,
   input logic [14:0]         i_chg_det,
   input logic                i_win_en,
   input logic                i_log_rd,
   // Watched outputs
   input logic                o_log_valid_q,
   input logic [LOG_AW:0]     o_log_count_q,
   input logic [LOG_AW-1:0]   o_log_head_q,
   input logic                o_chg_en_q,
   input logic                o_dsg_en_q,
   input logic [N_CELL-1:0]   o_bal_q,
   input logic [7:0]          o_flags_q,
   input logic                o_power_hold,
   input logic [3:0]          o_led_q
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   // Charging seen at the pins, same test as the design's detector
   wire chg = i_current < -$signed({1'b0, i_chg_det});
   ////////////////////////////////////////////////////////
   // Protection blocks the switches; charging clears overcurrent
   property p_temp_stop; |o_flags_q[6:3] |-> !o_chg_en_q && !o_dsg_en_q; endproperty
   a_temp_stop: assert property (p_temp_stop)
      else $error("switch on during temperature fault");
   property p_oc_stop; |o_flags_q[2:0] |-> !o_dsg_en_q; endproperty
   a_oc_stop: assert property (p_oc_stop)
      else $error("discharge on during overcurrent");
   property p_chg_clear; chg [*3] |-> o_flags_q[2:0] == 3'h0; endproperty
   a_chg_clear: assert property (p_chg_clear)
      else $error("charging left overcurrent state");
   // Power sequencing: sweep only while powered, nothing on when off
   property p_led_hold; o_led_q != 4'h0 |-> o_power_hold && $onehot(o_led_q); endproperty
   a_led_hold: assert property (p_led_hold)
      else $error("bad indicator sweep");
   property p_off_quiet; !o_power_hold |-> !o_chg_en_q && !o_dsg_en_q && o_led_q == 4'h0;
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("activity while off");
   // Log reader and writer
   property p_rd_valid; i_log_rd |=> o_log_valid_q; endproperty
   a_rd_valid: assert property (p_rd_valid)
      else $error("read not answered");
   property p_no_rd; !i_log_rd |=> !o_log_valid_q; endproperty
   a_no_rd: assert property (p_no_rd)
      else $error("valid without read");
   property p_count_step;
      o_log_count_q <= 2**LOG_AW &&
      (o_log_count_q == $past(o_log_count_q) || o_log_count_q == $past(o_log_count_q) + 1'b1);
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("record count jumped");
   property p_head_cnt; $changed(o_log_count_q) |-> $changed(o_log_head_q); endproperty
   a_head_cnt: assert property (p_head_cnt)
      else $error("count moved without head");
   property p_log_write;
      !i_win_en && o_flags_q != $past(o_flags_q) |-> ##[0:2] $changed(o_log_head_q);
   endproperty
   a_log_write: assert property (p_log_write)
      else $error("flag change not logged");
   // Main scenarios reached
   c_lock: cover property (o_flags_q[2]);
   c_bal: cover property (o_bal_q != '0);
   c_wake: cover property ($rose(o_power_hold));
   c_read: cover property (o_log_valid_q);
endmodule // bpc_checker

/* File: bpc_far_model.sv */
// Far-side model: load or charger current, user button and external switch
`timescale 1ns/10ps
module bpc_far_model (
   // Clock
   input  logic               i_sys_clk,
   // Commands from the sequence
   input  logic signed [15:0] i_amps,
   input  logic               i_press,
   input  logic               i_close,
   // Toward the device
   output logic signed [15:0] o_current,
   output logic               o_button,
   output logic               o_ext_sw
);
   // Idle levels at time zero
   initial begin
      o_current = 16'sh0000;
      o_button  = 1'b0;
      o_ext_sw  = 1'b0;
   end
   // Levels move just after the edge, never on it
   always @(posedge i_sys_clk) begin
      o_current <= #1 i_amps;
      o_button  <= #1 i_press;
      o_ext_sw  <= #1 i_close;
   end
endmodule // bpc_far_model

/* File: bpc_regs.vh */
// Named constants for the battery protection controller
`ifndef BPC_REGS_VH
`define BPC_REGS_VH

// Clock and time base
`define BPC_CLK_HZ       25000000
`define BPC_TICK_US      1000
`define BPC_HOLD_S       6
`define BPC_HOLD_MS      (`BPC_HOLD_S * 1000)
`define BPC_STEP_MS      250
`define BPC_SWEEP_STEPS  3'h4

// Power sequencing states
`define BPC_ST_OFF       3'h0
`define BPC_ST_WAKE      3'h1
`define BPC_ST_ON        3'h2
`define BPC_ST_SLEEP     3'h3

// Log geometry
`define BPC_LOG_DEPTH    512
`define BPC_REC_W        130

// Temperature sensor slots: cells first, then ambient and power stage
`define BPC_N_CTEMP      4
`define BPC_T_AMB        4
`define BPC_T_PWR        5

// Protection flag positions in the flag byte
`define BPC_F_OCD        0
`define BPC_F_TRN        1
`define BPC_F_LOCK       2
`define BPC_F_CHOT       3
`define BPC_F_CCOLD      4
`define BPC_F_AMB        5
`define BPC_F_PWR        6

`endif

/* File: bpc_top.v */
// Battery protection controller: overcurrent, temperature, balancing, power, history log
`timescale 1ns/10ps
`include "bpc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// One discharge overcurrent stage: trip after delay, optional timed recovery
module bpc_oc_stage (
   // Clock and reset
   input  wire        i_sys_clk,
   input  wire        i_arst_n,
   // Control
   input  wire        i_tick,
   input  wire        i_over,
   input  wire        i_clear,
   input  wire        i_rec_en,
   input  wire [15:0] i_dly_ms,
   input  wire [15:0] i_rec_ms,
   // Status
   output reg         o_trip_q,
   output reg         o_pulse_q
);
   reg [15:0] cnt_q;

   // Delay to trip, then wait and recheck the load current
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_trip_q  <= 1'b0;
         o_pulse_q <= 1'b0;
         cnt_q     <= 16'h0000;
      end else if (i_clear) begin
         o_trip_q  <= 1'b0;
         o_pulse_q <= 1'b0;
         cnt_q     <= 16'h0000;
      end else begin
         o_pulse_q <= 1'b0;
         if (!o_trip_q) begin
            if (!i_over) begin
               cnt_q <= 16'h0000;
            end else if (cnt_q >= i_dly_ms) begin
               o_trip_q  <= 1'b1;
               o_pulse_q <= 1'b1;
               cnt_q     <= 16'h0000;
            end else if (i_tick) begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end else if (i_rec_en && i_tick) begin
            if (cnt_q >= i_rec_ms) begin
               cnt_q <= 16'h0000;
               if (!i_over) begin
                  o_trip_q <= 1'b0;
               end
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
      end
   end
endmodule // bpc_oc_stage

////////////////////////////////////////////////////////////////////////////////
module bpc_top #(
   parameter N_CELL     = 8,
   parameter N_TEMP     = 6,
   parameter LOG_DEPTH  = `BPC_LOG_DEPTH,
   parameter LOG_AW     = 9,
   parameter P_TICK_CYC = `BPC_CLK_HZ / 1000000 * `BPC_TICK_US
) (
   // Clock and reset
   input  wire                   i_sys_clk,
   input  wire                   i_arst_n,
   // Measurements (same clock domain)
   input  wire signed [15:0]     i_current,
   input  wire [N_CELL*16-1:0]   i_cell_mv,
   input  wire [15:0]            i_total_v,
   input  wire [15:0]            i_capacity,
   input  wire [N_TEMP*8-1:0]    i_temp,
   // Configuration store
   input  wire [14:0]            i_chg_det,
   input  wire [14:0]            i_dsg_det,
   input  wire [14:0]            i_ocd_thr,
   input  wire [15:0]            i_ocd_dly_ms,
   input  wire [14:0]            i_trn_thr,
   input  wire [15:0]            i_trn_dly_ms,
   input  wire [15:0]            i_rec_dly_ms,
   input  wire [7:0]             i_lock_cnt,
   input  wire signed [7:0]      i_chot_thr,
   input  wire signed [7:0]      i_chot_rec,
   input  wire signed [7:0]      i_ccold_thr,
   input  wire signed [7:0]      i_ccold_rec,
   input  wire signed [7:0]      i_amb_thr,
   input  wire signed [7:0]      i_amb_rec,
   input  wire signed [7:0]      i_pwr_thr,
   input  wire signed [7:0]      i_pwr_rec,
   input  wire [15:0]            i_bal_start_mv,
   input  wire [15:0]            i_bal_diff_mv,
   // User pins (asynchronous)
   input  wire                   i_button,
   input  wire                   i_ext_sw,
   // Real-time clock
   input  wire [6:0]             i_ts_year,
   input  wire [3:0]             i_ts_month,
   input  wire [4:0]             i_ts_day,
   input  wire [4:0]             i_ts_hour,
   input  wire [5:0]             i_ts_min,
   input  wire [5:0]             i_ts_sec,
   // Recording window
   input  wire                   i_win_en,
   input  wire [10:0]            i_win_start,
   input  wire [10:0]            i_win_end,
   // Host log reader
   input  wire                   i_log_rd,
   input  wire [LOG_AW-1:0]      i_log_addr,
   output reg  [`BPC_REC_W-1:0]  o_log_data_q,
   output reg                    o_log_valid_q,
   output reg  [LOG_AW:0]        o_log_count_q,
   output reg  [LOG_AW-1:0]      o_log_head_q,
   // Switches, balancing and status
   output reg                    o_chg_en_q,
   output reg                    o_dsg_en_q,
   output reg  [N_CELL-1:0]      o_bal_q,
   output reg  [7:0]             o_flags_q,
   output wire                   o_power_hold,
   output reg  [3:0]             o_led_q
);
   // Pin synchronisers
   reg [1:0] btn_s_q;
   reg [1:0] ext_s_q;
   reg       btn_q;
   reg       ext_q;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         btn_s_q <= 2'h0;
         ext_s_q <= 2'h0;
         btn_q   <= 1'b0;
         ext_q   <= 1'b0;
      end else begin
         btn_s_q <= {btn_s_q[0], i_button};
         ext_s_q <= {ext_s_q[0], i_ext_sw};
         btn_q   <= btn_s_q[1];
         ext_q   <= ext_s_q[1];
      end
   end
   wire btn_rise = btn_s_q[1] & ~btn_q;
   wire ext_rise = ext_s_q[1] & ~ext_q;
   wire ext_fall = ~ext_s_q[1] & ext_q;

   // Millisecond tick; every delay counts in ticks to keep counters narrow
   reg [15:0] tick_cnt_q;
   wire       tick = (tick_cnt_q == P_TICK_CYC[15:0] - 16'h0001);
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) tick_cnt_q <= 16'h0000;
      else if (tick) tick_cnt_q <= 16'h0000;
      else tick_cnt_q <= tick_cnt_q + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Current direction and overcurrent stages
   reg  [2:0]  st_q;
   wire        on     = (st_q == `BPC_ST_ON);
   wire signed [16:0] cur_x = {i_current[15], i_current};
   wire chg  = cur_x < -$signed({2'b00, i_chg_det});
   wire dsg  = cur_x >  $signed({2'b00, i_dsg_det});
   wire ocd_over = cur_x > $signed({2'b00, i_ocd_thr});
   wire trn_over = cur_x > $signed({2'b00, i_trn_thr});
   wire oc_clear = ~on | chg;
   wire ocd_trip;
   wire trn_trip;
   wire trn_pulse;
   reg  lock_q;
   reg  [7:0] trips_q;

   // Slow stage recovers on its own; fast stage only until latched
   bpc_oc_stage u_ocd (
      .i_sys_clk (i_sys_clk), .i_arst_n (i_arst_n), .i_tick (tick),
      .i_over (ocd_over), .i_clear (oc_clear), .i_rec_en (1'b1),
      .i_dly_ms (i_ocd_dly_ms), .i_rec_ms (i_rec_dly_ms),
      .o_trip_q (ocd_trip), .o_pulse_q ()
   );
   bpc_oc_stage u_trn (
      .i_sys_clk (i_sys_clk), .i_arst_n (i_arst_n), .i_tick (tick),
      .i_over (trn_over), .i_clear (oc_clear), .i_rec_en (~lock_q),
      .i_dly_ms (i_trn_dly_ms), .i_rec_ms (i_rec_dly_ms),
      .o_trip_q (trn_trip), .o_pulse_q (trn_pulse)
   );

   // Transient trip counter and lock-out
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         trips_q <= 8'h00;
         lock_q  <= 1'b0;
      end else if (oc_clear) begin
         trips_q <= 8'h00;
         lock_q  <= 1'b0;
      end else if (trn_pulse) begin
         if (trips_q != 8'hff) trips_q <= trips_q + 8'h01;
         if (i_lock_cnt != 8'h00 && trips_q + 8'h01 >= i_lock_cnt)
            lock_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temperature evaluation: sensors 0..3 cells, 4 ambient, 5 power stage
   reg        any_hi, all_below_hrec, any_lo, all_above_lrec;
   reg signed [7:0] t_i;
   reg signed [7:0] t_max;
   integer k;
   always @* begin
      any_hi = 1'b0; all_below_hrec = 1'b1; any_lo = 1'b0; all_above_lrec = 1'b1;
      t_i = 8'sh00;
      t_max = $signed(i_temp[7:0]);
      for (k = 0; k < N_TEMP; k = k + 1) begin
         t_i = $signed(i_temp[k*8 +: 8]);
         if (t_i > t_max) t_max = t_i;
         if (k < `BPC_N_CTEMP) begin
            if (t_i > i_chot_thr) any_hi = 1'b1;
            if (!(t_i < i_chot_rec)) all_below_hrec = 1'b0;
            if (t_i < i_ccold_thr) any_lo = 1'b1;
            if (!(t_i > i_ccold_rec)) all_above_lrec = 1'b0;
         end
      end
   end
   wire signed [7:0] t_amb = $signed(i_temp[`BPC_T_AMB*8 +: 8]);
   wire signed [7:0] t_pwr = $signed(i_temp[`BPC_T_PWR*8 +: 8]);

   // Temperature flags; a set condition always beats the recovery condition
   reg chot_q, ccold_q, amb_q, pwr_q;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         chot_q <= 1'b0; ccold_q <= 1'b0; amb_q <= 1'b0; pwr_q <= 1'b0;
      end else begin
         if ((chg | dsg) & any_hi) chot_q <= 1'b1;
         else if (all_below_hrec) chot_q <= 1'b0;
         if ((chg | dsg) & any_lo) ccold_q <= 1'b1;
         else if (all_above_lrec) ccold_q <= 1'b0;
         if (t_amb > i_amb_thr) amb_q <= 1'b1;
         else if (t_amb < i_amb_rec) amb_q <= 1'b0;
         if (t_pwr > i_pwr_thr) pwr_q <= 1'b1;
         else if (t_pwr < i_pwr_rec) pwr_q <= 1'b0;
      end
   end

   // Switch drive; thresholds all arrive from the configuration store
   wire temp_stop = chot_q | ccold_q | amb_q | pwr_q;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_chg_en_q <= 1'b0;
         o_dsg_en_q <= 1'b0;
      end else begin
         o_chg_en_q <= on & ~temp_stop;
         o_dsg_en_q <= on & ~temp_stop & ~ocd_trip & ~trn_trip & ~lock_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cell spread for balancing and logging
   reg [15:0] v_max, v_min, v_i;
   reg        any_above;
   integer c;
   always @* begin
      v_max = 16'h0000; v_min = 16'hffff; v_i = 16'h0000; any_above = 1'b0;
      for (c = 0; c < N_CELL; c = c + 1) begin
         v_i = i_cell_mv[c*16 +: 16];
         if (v_i > v_max) v_max = v_i;
         if (v_i < v_min) v_min = v_i;
         if (v_i > i_bal_start_mv) any_above = 1'b1;
      end
   end
   wire [15:0] spread = v_max - v_min;

   // Balancing: bleed every cell above the lowest while active
   reg bal_act_q, chg_prev_q;
   integer b;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bal_act_q <= 1'b0; chg_prev_q <= 1'b0; o_bal_q <= {N_CELL{1'b0}};
      end else begin
         chg_prev_q <= chg;
         if (!on || dsg || (chg_prev_q && !chg) || spread < i_bal_diff_mv)
            bal_act_q <= 1'b0;
         else if (any_above && spread >= i_bal_diff_mv)
            bal_act_q <= 1'b1;
         for (b = 0; b < N_CELL; b = b + 1)
            o_bal_q[b] <= bal_act_q & (i_cell_mv[b*16 +: 16] > v_min);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power sequencing with indicator sweeps
   reg [15:0] ms_q;
   reg [15:0] hold_q;
   reg [2:0]  step_q;
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= `BPC_ST_OFF; ms_q <= 16'h0000; hold_q <= 16'h0000;
         step_q <= 3'h0; o_led_q <= 4'h0;
      end else begin
         case (st_q)
            `BPC_ST_OFF: begin
               o_led_q <= 4'h0;
               ms_q <= 16'h0000; step_q <= 3'h0; hold_q <= 16'h0000;
               if (ext_rise || btn_rise) st_q <= `BPC_ST_WAKE;
            end
            `BPC_ST_WAKE, `BPC_ST_SLEEP: begin
               o_led_q <= 4'h1 << step_q[1:0];
               if (tick) begin
                  if (ms_q >= `BPC_STEP_MS - 1) begin
                     ms_q <= 16'h0000;
                     if (step_q == `BPC_SWEEP_STEPS - 3'h1) begin
                        step_q <= 3'h0;
                        o_led_q <= 4'h0;           // Dark at sweep end; after a sleep sweep, on the same edge that the supply latch drops
                        st_q <= (st_q == `BPC_ST_WAKE) ? `BPC_ST_ON : `BPC_ST_OFF;
                     end else begin
                        step_q <= step_q + 3'h1;
                     end
                  end else begin
                     ms_q <= ms_q + 16'h0001;
                  end
               end
            end
            `BPC_ST_ON: begin
               o_led_q <= 4'h0;
               ms_q <= 16'h0000; step_q <= 3'h0;
               // External switch wins; while closed the button cannot sleep us
               if (ext_fall) begin
                  st_q <= `BPC_ST_SLEEP;
               end else if (!btn_s_q[1] || ext_q || chg) begin
                  hold_q <= 16'h0000;
               end else if (hold_q >= `BPC_HOLD_MS) begin
                  hold_q <= 16'h0000;
                  st_q <= `BPC_ST_SLEEP;
               end else if (tick) begin
                  hold_q <= hold_q + 16'h0001;
               end
            end
            default: st_q <= `BPC_ST_OFF;
         endcase
      end
   end
   // The latch drops only when the sleep sweep ends in the off state, so the board draws nothing
   assign o_power_hold = (st_q != `BPC_ST_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // History log
   reg  [`BPC_REC_W-1:0] log_mem [0:LOG_DEPTH-1];
   reg  [7:0] prev_q;
   wire [7:0] flags_now = {1'b0, pwr_q, amb_q, ccold_q, chot_q, lock_q, trn_trip, ocd_trip};
   wire [10:0] hm = {i_ts_hour, i_ts_min};
   wire in_win = ~i_win_en | ((hm >= i_win_start) & (hm <= i_win_end));
   wire rise = |(o_flags_q & ~prev_q);
   wire fall = |(~o_flags_q & prev_q);
   wire log_we = (rise | fall) & in_win;
   // Record: time, trip-or-recovery, flags, voltages, current, temperature, capacity
   wire [`BPC_REC_W-1:0] rec = {i_ts_year, i_ts_month, i_ts_day, i_ts_hour,
                                i_ts_min, i_ts_sec, rise, o_flags_q, i_total_v,
                                i_current, v_max, v_min, t_max, i_capacity};

   // Flag history and write pointer
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flags_q <= 8'h00; prev_q <= 8'h00;
         o_log_head_q <= {LOG_AW{1'b0}}; o_log_count_q <= {(LOG_AW+1){1'b0}};
      end else begin
         o_flags_q <= flags_now;
         prev_q <= o_flags_q;
         if (log_we) begin
            o_log_head_q <= o_log_head_q + 1'b1;
            if (o_log_count_q != LOG_DEPTH[LOG_AW:0])
               o_log_count_q <= o_log_count_q + 1'b1;
         end
      end
   end

   // Storage array, no reset so it maps to block memory
   always @(posedge i_sys_clk) begin
      if (log_we) log_mem[o_log_head_q] <= rec;
   end

   // Host read port, one cycle latency
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_log_data_q <= {`BPC_REC_W{1'b0}};
         o_log_valid_q <= 1'b0;
      end else begin
         o_log_valid_q <= i_log_rd;
         if (i_log_rd) o_log_data_q <= log_mem[i_log_addr];
      end
   end
endmodule // bpc_top

/* File: test_battery_protection_controller.sv */
// Self-checking testbench for the battery protection controller
`timescale 1ns/10ps
`include "bpc_regs.vh"
module test_battery_protection_controller;
   // Clock, reset and far-side commands
   logic i_sys_clk = 1'b0, i_arst_n = 1'b0, press = 1'b0, close = 1'b0, i_log_rd = 1'b0;
   logic signed [15:0] amps = 16'sh0000;
   wire signed [15:0] i_current;
   wire i_button, i_ext_sw;
   // Measurements, configuration, time and window (3400 mV cells, 25 C)
   logic [127:0] i_cell_mv = {8{16'h0d48}};
   logic [47:0] i_temp = {6{8'h19}};
   logic [15:0] i_total_v = 16'h6a40, i_capacity = 16'h1388, i_ocd_dly_ms = 16'h0005;
   logic [15:0] i_trn_dly_ms = 16'h0001, i_rec_dly_ms = 16'h0003;
   logic [15:0] i_bal_start_mv = 16'h0d7a, i_bal_diff_mv = 16'h0032;
   logic [14:0] i_chg_det = 15'h0014, i_dsg_det = 15'h0014;
   logic [14:0] i_ocd_thr = 15'h0064, i_trn_thr = 15'h00c8;
   logic [7:0] i_lock_cnt = 8'h02;
   logic signed [7:0] i_chot_thr = 8'sh3c, i_chot_rec = 8'sh32, i_ccold_thr = 8'shf6;
   logic signed [7:0] i_ccold_rec = 8'sh00, i_amb_thr = 8'sh46, i_amb_rec = 8'sh3c;
   logic signed [7:0] i_pwr_thr = 8'sh55, i_pwr_rec = 8'sh4b;
   logic [6:0] i_ts_year = 7'h19;
   logic [3:0] i_ts_month = 4'h6;
   logic [4:0] i_ts_day = 5'h0c, i_ts_hour = 5'h0a;
   logic [5:0] i_ts_min = 6'h1e, i_ts_sec = 6'h0f;
   logic i_win_en = 1'b0;
   logic [10:0] i_win_start = 11'h000, i_win_end = 11'h000;
   logic [8:0] i_log_addr = 9'h000;
   // Outputs
   wire [`BPC_REC_W-1:0] o_log_data_q;
   wire [9:0] o_log_count_q;
   wire [8:0] o_log_head_q;
   wire [7:0] o_bal_q, o_flags_q;
   wire [3:0] o_led_q;
   wire o_log_valid_q, o_chg_en_q, o_dsg_en_q, o_power_hold;
   int n_mismatch = 0, checked = 0;
   ////////////////////////////////////////////////////////
   // Short tick keeps the 6 s hold near 24000 cycles
   bpc_top #(.P_TICK_CYC(4)) dut_u (.*);
   bpc_far_model far_u (.i_sys_clk(i_sys_clk), .i_amps(amps), .i_press(press),
      .i_close(close), .o_current(i_current), .o_button(i_button), .o_ext_sw(i_ext_sw));
   always #20 i_sys_clk = ~i_sys_clk;
   ////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   // 0..7 flag bits, 8 supply latch, 9 both switches on
   function automatic logic probe(input int w);
      if (w < 8) return o_flags_q[w];
      if (w == 8) return o_power_hold;
      return o_chg_en_q & o_dsg_en_q;
   endfunction
   task automatic wait_for(input int w, input logic v, input int max, input string msg);
      int i;
      for (i = 0; i < max && probe(w) !== v; i++) cyc(1);
      if (i == max) begin
         chk(1'b0, msg);
         finish_test();
      end
   endtask
   // Read strobe stays up so reads can run back to back
   task automatic read_log(input logic [8:0] a, output logic [`BPC_REC_W-1:0] d);
      i_log_addr = a;
      i_log_rd = 1'b1;
      cyc(1);
      chk(o_log_valid_q === 1'b1, "read not answered");
      d = o_log_data_q;
   endtask
   ////////////////////////////////////////////////////////
   initial begin
      logic [`BPC_REC_W-1:0] rec;
      logic [9:0] cnt;
      int k;
      int tsel[4] = '{2, 1, 4, 5};
      int tbit[4] = '{3, 4, 5, 6};
      logic [7:0] tval[4] = '{8'h46, 8'hec, 8'h50, 8'h5a};
      cyc(5);
      i_arst_n = 1'b1;
      chk(o_power_hold === 1'b0 && o_flags_q === 8'h00 &&
          o_log_count_q === 10'h000, "reset");
      // Wake with a short press, sweep, then run
      press = 1'b1;
      cyc(5);
      press = 1'b0;
      wait_for(8, 1'b1, 8, "no wake");
      cyc(1);
      chk(o_led_q === 4'h1, "sweep start");
      wait_for(9, 1'b1, 4200, "no normal run");
      // Slow stage: 150 over 100 for 5 ticks, then automatic recovery
      amps = 16'sh0096;
      cyc(13);
      chk(o_flags_q[0] === 1'b0, "tripped before delay");
      wait_for(0, 1'b1, 40, "no slow trip");
      chk(o_dsg_en_q === 1'b0 && o_flags_q[1] === 1'b0, "slow trip");
      amps = 16'sh0032;
      wait_for(0, 1'b0, 80, "no recovery");
      cyc(2);
      chk(o_dsg_en_q === 1'b1 && o_log_count_q === 10'h002, "recovery");
      // Transient stage twice reaches the lock count of 2
      for (k = 0; k < 2; k++) begin
         amps = 16'sh012c;
         wait_for(1, 1'b1, 20, "no transient trip");
         amps = 16'sh0032;
         if (k == 0) wait_for(1, 1'b0, 80, "no transient recovery");
      end
      cyc(2);
      chk(o_flags_q[2] === 1'b1, "no lock");
      cyc(100);
      chk(o_flags_q[2:1] === 2'h3 && o_dsg_en_q === 1'b0, "lock lost");
      amps = -16'sh0064;
      cyc(4);
      chk(o_flags_q[2:0] === 3'h0 && o_dsg_en_q === 1'b1, "charge kept lock");
      // Each temperature fault while discharging, then recovery
      amps = 16'sh0032;
      for (k = 0; k < 4; k++) begin
         i_temp[tsel[k]*8 +: 8] = tval[k];
         wait_for(tbit[k], 1'b1, 10, "no temperature trip");
         cyc(2);
         chk(o_chg_en_q === 1'b0 && o_dsg_en_q === 1'b0, "switch on");
         i_temp[tsel[k]*8 +: 8] = 8'h19;
         wait_for(tbit[k], 1'b0, 10, "no temperature recovery");
         wait_for(9, 1'b1, 10, "no resume");
      end
      // Window at 00:00 drops records, 10:00 to 11:00 keeps them
      for (k = 0; k < 2; k++) begin
         i_win_start = k ? 11'h280 : 11'h000;
         i_win_end = k ? 11'h2c0 : 11'h000;
         i_win_en = 1'b1;
         cyc(3);
         cnt = o_log_count_q;
         i_temp[39:32] = 8'h50;
         wait_for(5, 1'b1, 10, "no ambient trip");
         i_temp[39:32] = 8'h19;
         wait_for(5, 1'b0, 10, "no ambient recovery");
         cyc(3);
         chk(o_log_count_q === cnt + (k ? 10'h002 : 10'h000), "window");
      end
      i_win_en = 1'b0;
      // First two records: slow trip then its recovery
      read_log(9'h000, rec);
      chk(rec[129:88] === {7'h19, 4'h6, 5'h0c, 5'h0a, 6'h1e, 6'h0f, 9'h101}, "rec 0");
      read_log(9'h001, rec);
      i_log_rd = 1'b0;
      chk(rec[96:88] === 9'h000, "rec 1");
      // Bleed while charging and in standby, off when spread under 50 mV
      amps = -16'sh0064;
      i_cell_mv[15:0] = 16'h0dac;
      cyc(4);
      chk(o_bal_q === 8'h01, "no charge bleed");
      amps = 16'sh0000;
      cyc(6);
      chk(o_bal_q === 8'h01, "no standby bleed");
      i_cell_mv[15:0] = 16'h0d66;
      cyc(4);
      chk(o_bal_q === 8'h00, "bleed stays on");
      // Six-second hold puts the pack to sleep
      press = 1'b1;
      cyc(23900);
      chk(o_power_hold === 1'b1 && o_led_q === 4'h0, "early sleep");
      wait_for(8, 1'b0, 5000, "no sleep");
      press = 1'b0;
      // External switch on and off
      close = 1'b1;
      wait_for(9, 1'b1, 4300, "no switch wake");
      close = 1'b0;
      wait_for(8, 1'b0, 4300, "no switch sleep");
      finish_test();
   end
endmodule // test_battery_protection_controller
bind bpc_top bpc_checker #(.N_CELL(N_CELL), .LOG_AW(LOG_AW)) chk_u (.*);
